// ---- design/usf_uart_ctl.sv ----
`timescale 1ns/100ps
module usf_uart_ctl
	import usf_pkg::*;
#(
	parameter int RX_DEPTH = 2
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire usf_req_t reg_req,
	output logic [7:0] reg_rdata,
	input wire logic rx_pin,
	input wire logic cts_n,
	output logic tx_pin,
	output logic rts_n,
	output logic driver_enable_out
);
	localparam int PW = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
	localparam int CW = $clog2(RX_DEPTH + 1);
	localparam logic [CW-1:0] RX_FULL_CNT = CW'(RX_DEPTH);

	logic [7:0] ctrl0;
	logic [7:0] uart_control_2;
	logic [7:0] brg;
	logic delayed_receive_irq;
	logic framing_error_flag;
	logic parity_error_flag;
	logic rx_overflow;
	logic tx_write_error;
	logic [7:0] csum;
	logic csum_first;
	logic xoff;

	wire on = ctrl0[CTRL0_ON];
	wire transmit_enable = ctrl0[CTRL0_TRANSMIT_ENABLE];
	wire rx_en = ctrl0[CTRL0_RXEN];
	wire par_en = ctrl0[CTRL0_PAREN];
	wire lin_mode = ctrl0[CTRL0_LIN];
	wire dali_mode = ctrl0[CTRL0_DALI];
	wire run_during_overflow = uart_control_2[CTRL2_RUN_DURING_OVERFLOW];
	wire rx_polarity = uart_control_2[CTRL2_RX_POLARITY];
	wire [1:0] stop_count_sel = uart_control_2[CTRL2_STP_HI:CTRL2_STP_LO];
	wire checksum_mode = uart_control_2[CTRL2_CSUM];
	wire tx_polarity = uart_control_2[CTRL2_TX_POLARITY];
	wire [1:0] flow_control_sel = uart_control_2[CTRL2_FLO_HI:CTRL2_FLO_LO];

	// register port decode
	wire wr_ctrl0 = reg_req.wr && reg_req.addr == OFS_CTRL0;
	wire wr_ctrl2 = reg_req.wr && reg_req.addr == OFS_CTRL2;
	wire wr_fifo = reg_req.wr && reg_req.addr == OFS_FIFO;
	wire wr_stat = reg_req.wr && reg_req.addr == OFS_STAT;
	wire wr_txb = reg_req.wr && reg_req.addr == OFS_TXB && on;
	wire wr_brg = reg_req.wr && reg_req.addr == OFS_BRG;
	wire wr_csum = reg_req.wr && reg_req.addr == OFS_CSUM;
	wire rd_rxb = reg_req.rd && reg_req.addr == OFS_RXB;

	// oversample tick, 16 per bit
	logic [7:0] div_cnt;
	logic tick;
	always_ff @(posedge core_clk) begin
		if (!rst_n || !on) begin
			div_cnt <= 8'h00;
			tick <= 1'b0;
		end else begin
			div_cnt <= (div_cnt == brg) ? 8'h00 : div_cnt + 8'h01;
			tick <= (div_cnt == brg);
		end
	end

	// pin synchronisers: bit 0 receive line, bit 1 clear-to-send
	logic [1:0] sy1;
	logic [1:0] sy2;
	logic [1:0] sy3;
	logic [1:0] pin_stable;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sy1 <= 2'h3;
			sy2 <= 2'h3;
			sy3 <= 2'h3;
			pin_stable <= 2'h3;
		end else begin
			sy1 <= {cts_n, rx_pin};
			sy2 <= sy1;
			sy3 <= sy2;
			pin_stable <= (sy2 & ~(sy2 ^ sy3)) | (pin_stable & (sy2 ^ sy3));
		end
	end
	wire rx_in = pin_stable[0] ^ rx_polarity;

	// receive path
	usf_rx_st_t rx_state;
	logic [3:0] rx_ph;
	logic [2:0] rx_bitn;
	logic [5:0] rx_stc;
	logic [7:0] rx_shift;
	logic rx_hold;
	logic [7:0] rx_mem [RX_DEPTH];
	logic [PW-1:0] rx_rd;
	logic [PW-1:0] rx_wr;
	logic [CW-1:0] rx_count;

	wire rx_full = rx_count == RX_FULL_CNT;
	wire rx_t = tick && rx_state == RX_STOP;
	wire at_c1 = rx_t && rx_stc == STC_C1;
	wire at_c2 = rx_t && rx_stc == STC_C2;
	wire both = stop_count_sel == STP_TWO_BOTH;
	wire rx_store = both ? at_c2 : at_c1;
	wire rx_verify_fail = (at_c1 || (at_c2 && both)) && !rx_in;
	// receive frame length per stop field
	wire [5:0] rx_end = (stop_count_sel == STP_ONE) ? RX_END_1 :
		(stop_count_sel == STP_ONEHALF) ? RX_END_15 : RX_END_2;
	wire end_stop = rx_t && rx_stc == rx_end;
	wire rx_par_err = tick && rx_state == RX_PAR && rx_ph == PH_LAST &&
		((^rx_shift) ^ rx_in);
	// words seen during overflow are dropped, framing kept
	wire push = rx_store && !rx_full && !rx_overflow;
	wire ovf_set = rx_store && rx_full;
	wire halt_now = ovf_set && !run_during_overflow;
	wire pop = rd_rxb && rx_count != '0;
	wire rx_flush = !on || (wr_fifo && reg_req.wdata[FIFO_RX_BUFFER_EMPTY]);

	always_ff @(posedge core_clk) begin
		if (!rst_n || !on || !rx_en) begin
			rx_state <= RX_IDLE;
			rx_ph <= 4'h0;
			rx_bitn <= 3'h0;
			rx_stc <= 6'h00;
			rx_shift <= 8'h00;
			rx_hold <= 1'b0;
		end else begin
			unique case (rx_state)
				RX_IDLE: begin
					if (tick && !rx_in) begin
						rx_state <= RX_START;
						rx_ph <= 4'h0;
					end
				end
				RX_START: begin
					if (tick && rx_ph == PH_HALF) begin
						rx_state <= rx_in ? RX_IDLE : RX_DATA;
						rx_ph <= 4'h0;
						rx_bitn <= 3'h0;
					end else if (tick) begin
						rx_ph <= rx_ph + 4'h1;
					end
				end
				RX_DATA: begin
					if (tick) begin
						rx_ph <= rx_ph + 4'h1;
					end
					if (tick && rx_ph == PH_LAST) begin
						rx_shift <= {rx_in, rx_shift[7:1]};
						rx_bitn <= rx_bitn + 3'h1;
						if (rx_bitn == 3'h7) begin
							rx_state <= par_en ? RX_PAR : RX_STOP;
							rx_stc <= 6'h00;
						end
					end
				end
				RX_PAR: begin
					if (tick) begin
						rx_ph <= rx_ph + 4'h1;
					end
					if (tick && rx_ph == PH_LAST) begin
						rx_state <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (tick) begin
						rx_stc <= rx_stc + 6'h01;
					end
					// halt or frame end clears the hold flag; a delayed push sets it
					if (halt_now) begin
						rx_state <= RX_HALT;
						rx_hold <= 1'b0;
					end else if (end_stop) begin
						rx_state <= RX_IDLE;
						rx_hold <= 1'b0;
					end else if (push && delayed_receive_irq) begin
						rx_hold <= 1'b1;
					end
				end
				RX_HALT: begin
					// restart blind: may resync mid-word
					if (!rx_overflow) begin
						rx_state <= RX_IDLE;
					end
				end
				default: begin
					rx_state <= RX_IDLE;
				end
			endcase
		end
	end

	// RX_DEPTH-entry receive buffer (two by default), read pops oldest
	always_ff @(posedge core_clk) begin
		if (push) begin
			rx_mem[rx_wr] <= rx_shift;
		end
	end
	always_ff @(posedge core_clk) begin
		if (!rst_n || rx_flush) begin
			rx_rd <= '0;
			rx_wr <= '0;
			rx_count <= '0;
		end else begin
			if (push) begin
				rx_wr <= PW'(rx_wr + 1'b1);
			end
			if (pop) begin
				rx_rd <= PW'(rx_rd + 1'b1);
			end
			rx_count <= rx_count + CW'(push) - CW'(pop);
		end
	end
	wire receive_irq_flag = rx_count != '0 && !rx_hold;
	wire rx_buffer_empty = !receive_irq_flag;

	// transmit path
	usf_tx_st_t tx_state;
	logic [3:0] tx_ph;
	logic [2:0] tx_bitn;
	logic [5:0] tx_stc;
	logic [7:0] tx_buf;
	logic tx_buf_valid;
	logic [7:0] tx_shift;
	logic tx_loaded;

	wire tx_active = tx_state == TX_START || tx_state == TX_DATA ||
		tx_state == TX_PAR;
	// direct path into a free shifter
	wire wr_direct = wr_txb && !tx_buf_valid && !tx_loaded;
	wire wr_buf = wr_txb && !tx_buf_valid && tx_loaded;
	wire buf_to_sh = tx_buf_valid && !tx_loaded;
	wire tx_reject = wr_txb && tx_buf_valid;
	wire tx_flush = wr_fifo && reg_req.wdata[FIFO_TX_BUFFER_EMPTY];
	wire flow_ok = (flow_control_sel == FLO_XON) ? !xoff :
		(flow_control_sel == FLO_HW) ? !pin_stable[1] : 1'b1;
	wire tx_go = tick && tx_state == TX_IDLE && tx_loaded &&
		transmit_enable && flow_ok;
	wire tx_bit_end = tick && tx_ph == PH_LAST;
	wire data_done = tx_bit_end && ((tx_state == TX_DATA &&
		tx_bitn == 3'h7 && !par_en) || tx_state == TX_PAR);
	wire [5:0] tx_end = (stop_count_sel == STP_ONE) ? TX_END_1 :
		(stop_count_sel == STP_ONEHALF) ? TX_END_15 : TX_END_2;
	// lighting mode chains words, stops only after the last
	wire dali_chain = dali_mode && tx_buf_valid;
	wire tx_bit = (tx_state == TX_START) ? 1'b0 :
		(tx_state == TX_DATA) ? tx_shift[tx_bitn] :
		(tx_state == TX_PAR) ? ^tx_shift : 1'b1;

	always_ff @(posedge core_clk) begin
		if (!rst_n || !on) begin
			tx_state <= TX_IDLE;
			tx_ph <= 4'h0;
			tx_bitn <= 3'h0;
			tx_stc <= 6'h00;
		end else begin
			unique case (tx_state)
				TX_IDLE: begin
					if (tx_go) begin
						tx_state <= TX_START;
						tx_ph <= 4'h0;
					end
				end
				TX_START: begin
					if (tick) begin
						tx_ph <= tx_ph + 4'h1;
					end
					if (tx_bit_end) begin
						tx_state <= TX_DATA;
						tx_bitn <= 3'h0;
					end
				end
				TX_DATA, TX_PAR: begin
					if (tick) begin
						tx_ph <= tx_ph + 4'h1;
					end
					if (tx_bit_end && tx_state == TX_DATA) begin
						tx_bitn <= tx_bitn + 3'h1;
						if (tx_bitn == 3'h7 && par_en) begin
							tx_state <= TX_PAR;
						end
					end
					if (data_done) begin
						tx_state <= dali_chain ? TX_IDLE : TX_STOP;
						tx_stc <= 6'h00;
					end
				end
				TX_STOP: begin
					if (tick) begin
						tx_stc <= tx_stc + 6'h01;
					end
					if (tick && tx_stc == tx_end) begin
						tx_state <= TX_IDLE;
					end
				end
				default: begin
					tx_state <= TX_IDLE;
				end
			endcase
		end
	end

	// off drops buffer and shifter contents
	always_ff @(posedge core_clk) begin
		if (!rst_n || !on) begin
			tx_buf_valid <= 1'b0;
			tx_loaded <= 1'b0;
			tx_buf <= 8'h00;
			tx_shift <= 8'h00;
		end else begin
			if (wr_buf) begin
				tx_buf <= reg_req.wdata;
			end
			if (wr_direct) begin
				tx_shift <= reg_req.wdata;
			end else if (buf_to_sh) begin
				tx_shift <= tx_buf;
			end
			if (tx_flush) begin
				tx_buf_valid <= 1'b0;
			end else if (wr_buf) begin
				tx_buf_valid <= 1'b1;
			end else if (buf_to_sh) begin
				tx_buf_valid <= 1'b0;
			end
			if (tx_flush && !tx_active) begin
				tx_loaded <= 1'b0;
			end else if (wr_direct || buf_to_sh) begin
				tx_loaded <= 1'b1;
			end else if (data_done) begin
				tx_loaded <= 1'b0;
			end
		end
	end
	wire transmit_irq_flag = !tx_buf_valid;
	wire tx_buffer_empty = transmit_irq_flag;
	wire tx_buffer_full = !transmit_irq_flag;

	wire csum_on = lin_mode ? (checksum_mode || !csum_first) : checksum_mode;
	wire [7:0] add_tx = (tx_go && csum_on) ? tx_shift : 8'h00;
	wire [7:0] add_rx = (push && csum_on) ? rx_shift : 8'h00;

	// control registers and sticky flags; a set beats a clear
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ctrl0 <= CTRL0_RST;
			uart_control_2 <= CTRL2_RST;
			brg <= BRG_RST;
			delayed_receive_irq <= 1'b0;
			framing_error_flag <= 1'b0;
			parity_error_flag <= 1'b0;
			rx_overflow <= 1'b0;
			tx_write_error <= 1'b0;
			csum <= 8'h00;
			csum_first <= 1'b1;
			xoff <= 1'b0;
		end else begin
			if (wr_ctrl0) begin
				ctrl0 <= reg_req.wdata;
			end
			if (wr_ctrl2) begin
				uart_control_2 <= reg_req.wdata;
			end
			if (wr_brg) begin
				brg <= reg_req.wdata;
			end
			if (wr_fifo) begin
				delayed_receive_irq <= reg_req.wdata[FIFO_DLY];
			end
			framing_error_flag <= rx_verify_fail | (framing_error_flag &
				!(wr_stat && reg_req.wdata[STAT_FERR]));
			parity_error_flag <= rx_par_err | (parity_error_flag &
				!(wr_stat && reg_req.wdata[STAT_PERR]));
			rx_overflow <= ovf_set | (rx_overflow & on &
				!(wr_stat && reg_req.wdata[STAT_OVF]));
			tx_write_error <= tx_reject | (tx_write_error &
				!(wr_fifo && reg_req.wdata[FIFO_TX_WRITE_ERROR]));
			if (wr_csum) begin
				csum <= 8'h00;
				csum_first <= 1'b1;
			end else begin
				csum <= csum + add_tx + add_rx;
				if (tx_go || push) begin
					csum_first <= 1'b0;
				end
			end
			if (push && flow_control_sel == FLO_XON) begin
				if (rx_shift == XOFF_CHAR) begin
					xoff <= 1'b1;
				end else if (rx_shift == XON_CHAR) begin
					xoff <= 1'b0;
				end
			end
		end
	end

	// read mux; the transmit offset OFS_TXB has no read path and reads as 00
	wire [7:0] fifo_view = {1'b0, delayed_receive_irq, tx_buffer_empty,
		tx_buffer_full, 1'b0, tx_write_error, rx_full, rx_buffer_empty};
	wire [7:0] stat_view = {3'h0, rx_overflow, parity_error_flag,
		framing_error_flag, transmit_irq_flag, receive_irq_flag};
	wire [7:0] rxb_view = (rx_count != '0) ? rx_mem[rx_rd] : 8'h00;
	wire [7:0] rd_mux = (reg_req.addr == OFS_CTRL0) ? ctrl0 :
		(reg_req.addr == OFS_CTRL2) ? uart_control_2 :
		(reg_req.addr == OFS_FIFO) ? fifo_view :
		(reg_req.addr == OFS_STAT) ? stat_view :
		(reg_req.addr == OFS_RXB) ? rxb_view :
		(reg_req.addr == OFS_BRG) ? brg :
		(reg_req.addr == OFS_CSUM) ? csum : 8'h00;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
			tx_pin <= 1'b1;
			rts_n <= 1'b0;
			driver_enable_out <= 1'b0;
		end else begin
			reg_rdata <= reg_req.rd ? rd_mux : 8'h00;
			tx_pin <= tx_bit ^ tx_polarity;
			rts_n <= (flow_control_sel == FLO_HW) && rx_full;
			driver_enable_out <= (flow_control_sel == FLO_HW) &&
				tx_state != TX_IDLE;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	chk_rx_flush_empties: assert property (
		wr_fifo && reg_req.wdata[FIFO_RX_BUFFER_EMPTY] |=> rx_count == '0 && !receive_irq_flag)
		else $error("receive flush left data");
	chk_tx_reject_err: assert property (
		tx_reject |=> tx_write_error && tx_buf == $past(tx_buf))
		else $error("full transmit write not rejected");
	chk_tx_direct_load: assert property (
		wr_direct |=> tx_loaded && !tx_buf_valid &&
			tx_shift == $past(reg_req.wdata))
		else $error("write did not pass to free shifter");
	chk_tx_held_off: assert property (
		tx_loaded && !transmit_enable && tx_state == TX_IDLE && on
			|=> tx_state == TX_IDLE && tx_loaded == !$past(tx_flush))
		else $error("transmit started while disabled");
	chk_ferr_prompt: assert property (
		rx_verify_fail |=> framing_error_flag)
		else $error("framing error not flagged");
	chk_rx_flag_now: assert property (
		push && !delayed_receive_irq |=> receive_irq_flag)
		else $error("receive flag late without delay");
	chk_rx_flag_late: assert property (
		push && delayed_receive_irq && rx_count == '0 && !halt_now
			|=> !receive_irq_flag)
		else $error("receive flag not delayed");
	chk_halt_stays: assert property (
		rx_state == RX_HALT && rx_overflow && on && rx_en
			|=> rx_state == RX_HALT)
		else $error("halted receiver resumed during overflow");
	chk_off_discard: assert property (
		!on |=> rx_count == '0 && !tx_loaded && !tx_buf_valid)
		else $error("module off kept data");
	chk_idle_pol: assert property (
		tx_state == TX_IDLE |=> tx_pin == !$past(tx_polarity))
		else $error("idle output level wrong");
	chk_rts_full: assert property (
		flow_control_sel == FLO_HW |=> rts_n == $past(rx_full))
		else $error("request-to-send not tracking full buffer");
endmodule

// ---- design/usf_pkg.sv ----
package usf_pkg;
	// register offsets on the plain register port
	localparam logic [2:0] OFS_CTRL0 = 3'h0;
	localparam logic [2:0] OFS_CTRL2 = 3'h1;
	localparam logic [2:0] OFS_FIFO = 3'h2;
	localparam logic [2:0] OFS_STAT = 3'h3;
	localparam logic [2:0] OFS_RXB = 3'h4;
	localparam logic [2:0] OFS_TXB = 3'h5;
	localparam logic [2:0] OFS_BRG = 3'h6;
	localparam logic [2:0] OFS_CSUM = 3'h7;
	// control 0 fields
	localparam int CTRL0_ON = 7;
	localparam int CTRL0_TRANSMIT_ENABLE = 5;
	localparam int CTRL0_RXEN = 4;
	localparam int CTRL0_PAREN = 2;
	localparam int CTRL0_LIN = 1;
	localparam int CTRL0_DALI = 0;
	// uart_control_2 fields
	localparam int CTRL2_RUN_DURING_OVERFLOW = 7;
	localparam int CTRL2_RX_POLARITY = 6;
	localparam int CTRL2_STP_HI = 5;
	localparam int CTRL2_STP_LO = 4;
	localparam int CTRL2_CSUM = 3;
	localparam int CTRL2_TX_POLARITY = 2;
	localparam int CTRL2_FLO_HI = 1;
	localparam int CTRL2_FLO_LO = 0;
	// buffer_status_reg fields
	localparam int FIFO_RX_BUFFER_EMPTY = 0;
	localparam int FIFO_RX_BUFFER_FULL = 1;
	localparam int FIFO_TX_WRITE_ERROR = 2;
	localparam int FIFO_TX_BUFFER_FULL = 4;
	localparam int FIFO_TX_BUFFER_EMPTY = 5;
	localparam int FIFO_DLY = 6;
	// status fields
	localparam int STAT_FERR = 2;
	localparam int STAT_PERR = 3;
	localparam int STAT_OVF = 4;
	// reset values
	localparam logic [7:0] CTRL0_RST = 8'h00;
	localparam logic [7:0] CTRL2_RST = 8'h00;
	localparam logic [7:0] BRG_RST = 8'h1A;
	// stop and flow codes
	localparam logic [1:0] STP_ONE = 2'h0;
	localparam logic [1:0] STP_ONEHALF = 2'h1;
	localparam logic [1:0] STP_TWO_BOTH = 2'h2;
	localparam logic [1:0] FLO_XON = 2'h1;
	localparam logic [1:0] FLO_HW = 2'h2;
	localparam logic [7:0] XON_CHAR = 8'h11;
	localparam logic [7:0] XOFF_CHAR = 8'h13;
	// timing in oversample ticks, 16 per bit
	localparam logic [3:0] PH_HALF = 4'h7;
	localparam logic [3:0] PH_LAST = 4'hF;
	localparam logic [5:0] STC_C1 = 6'h0F;
	localparam logic [5:0] STC_C2 = 6'h1F;
	localparam logic [5:0] RX_END_1 = 6'h17;
	localparam logic [5:0] RX_END_15 = 6'h1F;
	localparam logic [5:0] RX_END_2 = 6'h27;
	localparam logic [5:0] TX_END_1 = 6'h0F;
	localparam logic [5:0] TX_END_15 = 6'h17;
	localparam logic [5:0] TX_END_2 = 6'h1F;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} usf_req_t;

	typedef enum logic [2:0] {
		RX_IDLE = 3'h0,
		RX_START = 3'h1,
		RX_DATA = 3'h2,
		RX_PAR = 3'h3,
		RX_STOP = 3'h4,
		RX_HALT = 3'h5
	} usf_rx_st_t;

	typedef enum logic [2:0] {
		TX_IDLE = 3'h0,
		TX_START = 3'h1,
		TX_DATA = 3'h2,
		TX_PAR = 3'h3,
		TX_STOP = 3'h4
	} usf_tx_st_t;
endpackage

// ---- dv/usf_remote.sv ----
`timescale 1ns/100ps
module usf_remote (
	input wire logic core_clk,
	input wire logic tx_pin,
	input wire logic rx_inv,
	input wire logic tx_inv,
	output logic rx_pin,
	output logic cts_n,
	output logic [7:0] got_byte,
	output logic got_stb,
	output int period
);
	logic busy = 1'b0;
	logic bitv = 1'b1;
	int cnt = 0;
	int last = 0;

	// line idles at the level set by polarity
	assign rx_pin = (busy ? bitv : 1'b1) ^ rx_inv;
	// remote always ready, so hardware flow never stalls us
	assign cts_n = 1'b0;

	initial begin
		got_stb = 1'b0;
		got_byte = 8'h00;
		period = 0;
	end

	always @(posedge core_clk) cnt <= cnt + 1;

	// stop bits idle unless bad asks for a low one
	task automatic send(input logic [7:0] b, input int nstop,
		input logic [1:0] bad);
		logic [10:0] f;
		f = {~bad[1], ~bad[0], b, 1'b0};
		for (int i = 0; i < 9 + nstop; i++) begin
			@(posedge core_clk);
			bitv <= f[i];
			busy <= 1'b1;
			repeat (15) @(posedge core_clk);
		end
		@(posedge core_clk);
		busy <= 1'b0;
	endtask

	// start must still be low at its centre, so glitches are dropped
	always begin
		@(posedge core_clk);
		if ((tx_pin ^ tx_inv) === 1'b0) begin
			repeat (8) @(posedge core_clk);
			if ((tx_pin ^ tx_inv) === 1'b0) begin
				period = cnt - last;
				last = cnt;
				for (int i = 0; i < 8; i++) begin
					repeat (16) @(posedge core_clk);
					got_byte[i] = tx_pin ^ tx_inv;
				end
				repeat (16) @(posedge core_clk);
				got_stb = 1'b1;
				@(posedge core_clk);
				got_stb = 1'b0;
			end
		end
	end
endmodule

// ---- dv/usf_uart_ctl_test.sv ----
`timescale 1ns/100ps
module usf_uart_ctl_test
	import usf_pkg::*;
;
	logic core_clk = 1'b0;
	logic rst_n;
	usf_req_t reg_req;
	logic [7:0] reg_rdata;
	logic rx_pin, cts_n, tx_pin, rts_n, driver_enable_out;
	logic rx_inv, tx_inv, got_stb, pend;
	logic [7:0] got_byte, b, c;
	logic [7:0] v[3];
	logic [7:0] txq[$];
	logic [7:0] rq_exp[$];
	logic [7:0] rq_msk[$];
	int period;
	int fail_count = 0;
	int num_checks = 0;
	int stp_len[4] = '{16, 24, 32, 32};

	always #10 core_clk = ~core_clk;

	usf_uart_ctl #(.RX_DEPTH(2)) usf_uart_ctl_i (
		.core_clk(core_clk), .rst_n(rst_n), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .rx_pin(rx_pin), .cts_n(cts_n),
		.tx_pin(tx_pin), .rts_n(rts_n),
		.driver_enable_out(driver_enable_out));

	usf_remote remote_i (
		.core_clk(core_clk), .tx_pin(tx_pin), .rx_inv(rx_inv),
		.tx_inv(tx_inv), .rx_pin(rx_pin), .cts_n(cts_n),
		.got_byte(got_byte), .got_stb(got_stb), .period(period));

	task automatic bad(input logic ok, input string m);
		num_checks++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		bad(got === exp, $sformatf("got %h want %h", got, exp));
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		reg_req.wr <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] e,
		input logic [7:0] m);
		rq_exp.push_back(e);
		rq_msk.push_back(m);
		@(posedge core_clk);
		reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		reg_req.rd <= 1'b0;
	endtask

	task automatic bits(input int n);
		repeat (n * 16) @(posedge core_clk);
	endtask

	task automatic done(input string s);
		$display("test %s done", s);
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// read data stand only in the cycle after the strobe
	always @(negedge core_clk) begin
		if (pend)
			chk(reg_rdata & rq_msk.pop_front(), rq_exp.pop_front());
		pend = reg_req.rd;
	end

	always @(posedge got_stb) begin
		if (txq.size() == 0)
			bad(1'b0, "word sent with none pending");
		else
			chk(got_byte, txq.pop_front());
	end

	initial begin
		repeat (40000) @(posedge core_clk);
		fail_count++;
		conclude();
	end

	initial begin
		void'($urandom(32'he78e_3267));
		reg_req = '0;
		rst_n = 1'b0;
		rx_inv = 1'b0;
		tx_inv = 1'b0;
		pend = 1'b0;
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(OFS_CTRL2, 8'h00, 8'hFF);
		chk({7'h00, tx_pin}, 8'h01);
		wr(OFS_BRG, 8'h00);
		wr(OFS_CTRL0, 8'hB0);
		done("reset");
		for (int s = 0; s < 4; s++) begin
			wr(OFS_CTRL2, 8'(s << 4));
			b = 8'($urandom);
			c = 8'($urandom);
			txq.push_back(b);
			txq.push_back(c);
			wr(OFS_TXB, b);
			wr(OFS_TXB, c);
			wr(OFS_TXB, ~c);
			rd(OFS_FIFO, 8'h14, 8'h34);
			wr(OFS_FIFO, 8'h04);
			bits(26);
			bad(period >= 142 + stp_len[s] &&
				period <= 146 + stp_len[s], "word spacing");
		end
		done("tx stops");
		wr(OFS_CTRL2, 8'h00);
		wr(OFS_CTRL0, 8'h90);
		b = 8'($urandom);
		wr(OFS_TXB, b);
		bits(12);
		txq.push_back(b);
		wr(OFS_CTRL0, 8'hB0);
		bits(12);
		wr(OFS_CTRL0, 8'h90);
		wr(OFS_TXB, b);
		wr(OFS_FIFO, 8'h20);
		wr(OFS_CTRL0, 8'hB0);
		bits(12);
		wr(OFS_CTRL0, 8'h90);
		wr(OFS_TXB, b);
		wr(OFS_CTRL0, 8'h00);
		wr(OFS_CTRL0, 8'hB0);
		bits(12);
		done("tx hold");
		b = 8'($urandom);
		c = 8'($urandom);
		remote_i.send(b, 1, 2'b00);
		remote_i.send(c, 1, 2'b00);
		bits(2);
		rd(OFS_FIFO, 8'h02, 8'h03);
		rd(OFS_STAT, 8'h01, 8'h01);
		rd(OFS_RXB, b, 8'hFF);
		rd(OFS_RXB, c, 8'hFF);
		rd(OFS_STAT, 8'h00, 8'h01);
		rd(OFS_FIFO, 8'h01, 8'h03);
		done("rx buffer");
		// a low second stop may start a stray frame, flushed below
		for (int s = 0; s < 4; s++) begin
			wr(OFS_CTRL2, 8'(s << 4));
			b = 8'($urandom);
			remote_i.send(b, 2, 2'b10);
			bits(12);
			rd(OFS_STAT, (s == 2) ? 8'h04 : 8'h00, 8'h04);
			rd(OFS_RXB, b, 8'hFF);
			wr(OFS_FIFO, 8'h01);
			rd(OFS_FIFO, 8'h01, 8'h01);
			wr(OFS_STAT, 8'h1C);
		end
		wr(OFS_CTRL2, 8'h00);
		remote_i.send(b, 1, 2'b01);
		bits(12);
		rd(OFS_STAT, 8'h04, 8'h04);
		wr(OFS_STAT, 8'h1C);
		wr(OFS_FIFO, 8'h01);
		done("framing");
		wr(OFS_CTRL2, 8'h80);
		for (int i = 0; i < 3; i++) begin
			v[i] = 8'($urandom);
			remote_i.send(v[i], 1, 2'b00);
		end
		bits(2);
		rd(OFS_STAT, 8'h10, 8'h10);
		rd(OFS_RXB, v[0], 8'hFF);
		rd(OFS_RXB, v[1], 8'hFF);
		wr(OFS_STAT, 8'h10);
		remote_i.send(v[2], 1, 2'b00);
		bits(2);
		rd(OFS_RXB, v[2], 8'hFF);
		wr(OFS_CTRL2, 8'h00);
		for (int i = 0; i < 3; i++) begin
			remote_i.send(v[i], 1, 2'b00);
		end
		bits(2);
		rd(OFS_STAT, 8'h10, 8'h10);
		rd(OFS_RXB, v[0], 8'hFF);
		rd(OFS_RXB, v[1], 8'hFF);
		rd(OFS_FIFO, 8'h01, 8'h01);
		wr(OFS_STAT, 8'h10);
		done("overflow");
		wr(OFS_CTRL2, 8'h40);
		rx_inv <= 1'b1;
		bits(12);
		wr(OFS_FIFO, 8'h01);
		b = 8'($urandom);
		remote_i.send(b, 1, 2'b00);
		bits(2);
		rd(OFS_RXB, b, 8'hFF);
		wr(OFS_CTRL2, 8'h04);
		rx_inv <= 1'b0;
		tx_inv <= 1'b1;
		bits(12);
		wr(OFS_FIFO, 8'h01);
		wr(OFS_STAT, 8'h1C);
		txq.push_back(b);
		wr(OFS_TXB, b);
		bits(12);
		chk({7'h00, tx_pin}, 8'h00);
		done("polarity");
		wr(OFS_CTRL2, 8'h02);
		tx_inv <= 1'b0;
		bits(12);
		remote_i.send(b, 1, 2'b00);
		remote_i.send(c, 1, 2'b00);
		bits(2);
		chk({7'h00, rts_n}, 8'h01);
		rd(OFS_RXB, b, 8'hFF);
		bits(1);
		chk({7'h00, rts_n}, 8'h00);
		rd(OFS_RXB, c, 8'hFF);
		txq.push_back(c);
		wr(OFS_TXB, c);
		bits(4);
		chk({7'h00, driver_enable_out}, 8'h01);
		bits(12);
		chk({7'h00, driver_enable_out}, 8'h00);
		remote_i.send(b, 1, 2'b00);
		bits(1);
		wr(OFS_CTRL0, 8'h00);
		wr(OFS_CTRL0, 8'hB0);
		rd(OFS_FIFO, 8'h01, 8'h01);
		bits(1);
		done("flow and off");
		wr(OFS_CTRL2, 8'h01);
		remote_i.send(XOFF_CHAR, 1, 2'b00);
		wr(OFS_TXB, b);
		// noted late: a word sent while paused finds no note
		bits(12);
		txq.push_back(b);
		remote_i.send(XON_CHAR, 1, 2'b00);
		bits(12);
		wr(OFS_FIFO, 8'h01);
		done("soft flow");
		wr(OFS_CTRL2, 8'h08);
		wr(OFS_CSUM, 8'h00);
		txq.push_back(c);
		wr(OFS_TXB, c);
		remote_i.send(b, 1, 2'b00);
		bits(12);
		rd(OFS_CSUM, 8'(b + c), 8'hFF);
		wr(OFS_FIFO, 8'h01);
		wr(OFS_CTRL0, 8'hB2);
		wr(OFS_CTRL2, 8'h00);
		wr(OFS_CSUM, 8'h00);
		remote_i.send(b, 1, 2'b00);
		remote_i.send(c, 1, 2'b00);
		bits(2);
		rd(OFS_CSUM, c, 8'hFF);
		done("checksum");
		wr(OFS_CTRL0, 8'hB4);
		wr(OFS_FIFO, 8'h41);
		// wrong even parity in the tenth cell, good stop after it
		remote_i.send(b, 2, {1'b0, ^b});
		bits(2);
		rd(OFS_STAT, 8'h09, 8'h0D);
		wr(OFS_STAT, 8'h1C);
		wr(OFS_FIFO, 8'h01);
		wr(OFS_CTRL0, 8'hB0);
		done("parity");
		conclude();
	end
endmodule
